// [pmst_regs.v]
// power setting and drive-motion self-test register bank
//
// Notes on behaviour
// - bits [2:0] of power register pick active-mode power: 000/011/100
// - bits [6:4] of power register pick watch-mode power, same codes
// - bit 7 of power register always reads back as zero
// - x bit 2 set drives the element in positive x
// - x bit 3 set drives the element in negative x
// - y register reads 0x80 in running modes, 0x00 in sleep/standby
// - y bit 2 set drives the element in positive y
// - y bit 3 set drives the element in negative y
// - z bit 2 set drives the element in positive z
// - z bit 3 set drives the element in negative z
// - activity seen in watch mode raises a wake request; the mode switch is left upstream
`timescale 1ns/1ps
module pmst_regs (
    clk,
    arst_n,
    addr,
    wdata,
    wr,
    rd,
    rdata_ff,
    op_mode,
    activity,
    act_pwr_sel_ff,
    watch_pwr_sel_ff,
    wake_req_ff,
    hs_enable_ff,
    x_pos_ff,
    x_neg_ff,
    y_pos_ff,
    y_neg_ff,
    z_pos_ff,
    z_neg_ff,
    x_init_ff,
    y_init_ff
);
`include "pmst_defines.vh"
    input  wire       clk;
    input  wire       arst_n;
    input  wire [7:0] addr;
    input  wire [7:0] wdata;
    input  wire       wr;
    input  wire       rd;
    output reg  [7:0] rdata_ff;
    input  wire [2:0] op_mode;
    input  wire       activity;
    output wire [1:0] act_pwr_sel_ff;
    output wire [1:0] watch_pwr_sel_ff;
    output reg        wake_req_ff;
    output reg        hs_enable_ff;
    output reg        x_pos_ff;
    output reg        x_neg_ff;
    output reg        y_pos_ff;
    output reg        y_neg_ff;
    output reg        z_pos_ff;
    output reg        z_neg_ff;
    output reg        x_init_ff;
    output reg        y_init_ff;

    ////////////////////////////////////////////////////////////////////////
    // stored fields and their next values
    reg  [2:0] act_pwr_ff;
    reg  [2:0] watch_pwr_ff;
    reg  [2:0] nxt_act_pwr;
    reg  [2:0] nxt_watch_pwr;
    reg        nxt_hs_enable;
    reg        nxt_x_pos;
    reg        nxt_x_neg;
    reg        nxt_x_init;
    reg        nxt_y_pos;
    reg        nxt_y_neg;
    reg        nxt_y_init;
    reg        nxt_z_pos;
    reg        nxt_z_neg;
    reg        nxt_wake_req;
    reg  [7:0] nxt_rdata;

    // strobes qualified by an exact address match
    wire       wr_pwr;
    wire       wr_x;
    wire       wr_y;
    wire       wr_z;
    wire       running;

    // exact byte compare; a partial decode would alias the neighbours
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // sleep and standby report idle, every other code counts as running
    // unassigned codes are treated as running too
    function is_running;
        input [2:0] mode;
        begin
            case (mode)
                `PMST_MODE_SLEEP,
                `PMST_MODE_STANDBY: is_running = 1'b0;
                default:            is_running = 1'b1;
            endcase
        end
    endfunction

    // power image; the high-speed bit and reserved bit 3 read zero
    function [7:0] pwr_image;
        input [2:0] act;
        input [2:0] watch;
        begin
            pwr_image = `PMST_RST_BYTE;
            pwr_image[`PMST_ACT_MSB:`PMST_ACT_LSB]     = act;
            pwr_image[`PMST_WATCH_MSB:`PMST_WATCH_LSB] = watch;
            pwr_image[`PMST_HS_BIT]                    = 1'b0;
        end
    endfunction

    // drive image: only the two direction bits are kept
    function [7:0] drv_image;
        input pos;
        input neg;
        begin
            drv_image = `PMST_RST_BYTE;
            drv_image[`PMST_POS_BIT] = pos;
            drv_image[`PMST_NEG_BIT] = neg;
        end
    endfunction

    assign wr_pwr  = wr && hit(addr, `PMST_OFF_POWER);
    assign wr_x    = wr && hit(addr, `PMST_OFF_XDRV);
    assign wr_y    = wr && hit(addr, `PMST_OFF_YDRV);
    assign wr_z    = wr && hit(addr, `PMST_OFF_ZDRV);
    assign running = is_running(op_mode);

    ////////////////////////////////////////////////////////////////////////
    // power register: both fields and the high-speed bit load together
    always @* begin
        nxt_act_pwr   = act_pwr_ff;
        nxt_watch_pwr = watch_pwr_ff;
        nxt_hs_enable = hs_enable_ff;
        if (wr_pwr) begin
            nxt_act_pwr   = wdata[`PMST_ACT_MSB:`PMST_ACT_LSB];
            nxt_watch_pwr = wdata[`PMST_WATCH_MSB:`PMST_WATCH_LSB];
            // write-only; readback hides it, so the host keeps a copy
            nxt_hs_enable = wdata[`PMST_HS_BIT];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            act_pwr_ff   <= `PMST_PWR_LOW;
            watch_pwr_ff <= `PMST_PWR_LOW;
            hs_enable_ff <= 1'b0;
        end else begin
            act_pwr_ff   <= nxt_act_pwr;
            watch_pwr_ff <= nxt_watch_pwr;
            hs_enable_ff <= nxt_hs_enable;
        end
    end

    // decoders add a cycle: select outputs follow a write by two

    pmst_pwr_decode u_act_dec (
        .clk    (clk),
        .arst_n (arst_n),
        .code   (act_pwr_ff),
        .sel_ff (act_pwr_sel_ff)
    );

    pmst_pwr_decode u_watch_dec (
        .clk    (clk),
        .arst_n (arst_n),
        .code   (watch_pwr_ff),
        .sel_ff (watch_pwr_sel_ff)
    );

    ////////////////////////////////////////////////////////////////////////
    // x drive register: write-only, the stored bits never reach rdata
    // both directions may be set at once; nothing arbitrates them
    always @* begin
        nxt_x_pos  = x_pos_ff;
        nxt_x_neg  = x_neg_ff;
        nxt_x_init = x_init_ff;
        if (wr_x) begin
            nxt_x_pos  = wdata[`PMST_POS_BIT];
            nxt_x_neg  = wdata[`PMST_NEG_BIT];
            nxt_x_init = wdata[`PMST_XINIT_BIT];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            x_pos_ff  <= 1'b0;
            x_neg_ff  <= 1'b0;
            x_init_ff <= 1'b0;
        end else begin
            x_pos_ff  <= nxt_x_pos;
            x_neg_ff  <= nxt_x_neg;
            x_init_ff <= nxt_x_init;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // y drive register: readback follows the mode, not these bits
    always @* begin
        nxt_y_pos  = y_pos_ff;
        nxt_y_neg  = y_neg_ff;
        nxt_y_init = y_init_ff;
        if (wr_y) begin
            nxt_y_pos  = wdata[`PMST_POS_BIT];
            nxt_y_neg  = wdata[`PMST_NEG_BIT];
            nxt_y_init = wdata[`PMST_YINIT_BIT];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            y_pos_ff  <= 1'b0;
            y_neg_ff  <= 1'b0;
            y_init_ff <= 1'b0;
        end else begin
            y_pos_ff  <= nxt_y_pos;
            y_neg_ff  <= nxt_y_neg;
            y_init_ff <= nxt_y_init;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // z drive register: reserved bits are not kept
    always @* begin
        nxt_z_pos = z_pos_ff;
        nxt_z_neg = z_neg_ff;
        if (wr_z) begin
            nxt_z_pos = wdata[`PMST_POS_BIT];
            nxt_z_neg = wdata[`PMST_NEG_BIT];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            z_pos_ff <= 1'b0;
            z_neg_ff <= 1'b0;
        end else begin
            z_pos_ff <= nxt_z_pos;
            z_neg_ff <= nxt_z_neg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one pulse per activity cycle while watching; mode change is upstream
    always @* begin
        nxt_wake_req = activity &&
                       (op_mode == `PMST_MODE_WATCH);
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_req_ff <= 1'b0;
        end else begin
            wake_req_ff <= nxt_wake_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data is zero except in the cycle after a read strobe
    always @* begin
        nxt_rdata = `PMST_RST_BYTE;
        if (rd) begin
            case (addr)
                `PMST_OFF_POWER: begin
                    nxt_rdata = pwr_image(act_pwr_ff, watch_pwr_ff);
                end
                `PMST_OFF_YDRV: begin
                    nxt_rdata = running ? `PMST_Y_LIVE : `PMST_Y_IDLE;
                end
                `PMST_OFF_ZDRV: begin
                    nxt_rdata = drv_image(z_pos_ff, z_neg_ff);
                end
                // write-only x and unmapped bytes read as zero
                default: begin
                    nxt_rdata = `PMST_RST_BYTE;
                end
            endcase
        end
    end

    // registered so the host sees a settled byte for one full cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= `PMST_RST_BYTE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule

// [pmst_defines.vh]
// register offsets, field positions and codes for the power/self-test bank
`ifndef PMST_DEFINES_VH
`define PMST_DEFINES_VH

`define PMST_ADDR_W          8
`define PMST_OFF_POWER       8'h1c
`define PMST_OFF_XDRV        8'h20
`define PMST_OFF_YDRV        8'h21
`define PMST_OFF_ZDRV        8'h22
`define PMST_OFF_OPMODE      8'h10

`define PMST_RST_BYTE        8'h00
`define PMST_ACT_LSB         0
`define PMST_ACT_MSB         2
`define PMST_WATCH_LSB       4
`define PMST_WATCH_MSB       6
`define PMST_HS_BIT          7
`define PMST_POS_BIT         2
`define PMST_NEG_BIT         3
`define PMST_XINIT_BIT       0
`define PMST_YINIT_BIT       7

`define PMST_PWR_LOW         3'h0
`define PMST_PWR_ULTRA       3'h3
`define PMST_PWR_PREC        3'h4

`define PMST_SEL_LOW         2'h0
`define PMST_SEL_ULTRA       2'h1
`define PMST_SEL_PREC        2'h2

`define PMST_Y_LIVE          8'h80
`define PMST_Y_IDLE          8'h00

`define PMST_MODE_SLEEP      3'h0
`define PMST_MODE_WATCH      3'h2
`define PMST_MODE_STANDBY    3'h1
`define PMST_MODE_ACTIVE     3'h5
`define PMST_MODE_SWATCH     3'h6
`define PMST_MODE_TRIGGERED_CAPTURE_MODE       3'h7

`endif

// [pmst_pwr_decode.v]
// decodes a 3-bit power setting and holds it, reserved codes fall back low
`timescale 1ns/1ps
module pmst_pwr_decode (
    clk,
    arst_n,
    code,
    sel_ff
);
`include "pmst_defines.vh"
    input  wire       clk;
    input  wire       arst_n;
    input  wire [2:0] code;
    output reg  [1:0] sel_ff;

    reg [1:0] nxt_sel;

    // one-hot-ish select: 00 low, 01 ultra-low, 10 precision
    always @* begin
        case (code)
            `PMST_PWR_ULTRA: nxt_sel = `PMST_SEL_ULTRA;
            `PMST_PWR_PREC:  nxt_sel = `PMST_SEL_PREC;
            default:         nxt_sel = `PMST_SEL_LOW;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_ff <= `PMST_SEL_LOW;
        end else begin
            sel_ff <= nxt_sel;
        end
    end
endmodule

// [pmst_regs_checker.sv]
// concurrent checks for the power and self-test register bank
`timescale 1ns/1ps
module pmst_regs_checker (
    input wire       clk,
    input wire       arst_n,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata_ff,
    input wire [2:0] op_mode,
    input wire       activity,
    input wire [1:0] act_pwr_sel_ff,
    input wire [1:0] watch_pwr_sel_ff,
    input wire       wake_req_ff,
    input wire       x_pos_ff,
    input wire       y_neg_ff,
    input wire       z_pos_ff,
    input wire       z_neg_ff,
    input wire       hs_enable_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////
    a_x_pos_drive: assert property (
        wr && addr == 8'h20 |=> x_pos_ff == $past(wdata[2]))
        else $error("x positive drive wrong");
    a_y_neg_drive: assert property (
        wr && addr == 8'h21 |=> y_neg_ff == $past(wdata[3]))
        else $error("y negative drive wrong");
    a_z_pos_drive: assert property (
        wr && addr == 8'h22 |=> z_pos_ff == $past(wdata[2]))
        else $error("z positive drive wrong");
    // sleep and standby are the only idle codes
    a_y_mode_read: assert property (
        rd && addr == 8'h21 |=> rdata_ff ==
        (($past(op_mode) < 3'h2) ? 8'h00 : 8'h80))
        else $error("y readback wrong");
    a_hs_bit_hidden: assert property (
        rd && addr == 8'h1c |=> !rdata_ff[7])
        else $error("high speed bit visible");
    a_act_precision: assert property (
        wr && addr == 8'h1c && wdata[2:0] == 3'h4
        |-> ##2 act_pwr_sel_ff == 2'h2)
        else $error("active power select wrong");
    a_watch_ultra: assert property (
        wr && addr == 8'h1c && wdata[6:4] == 3'h3
        |-> ##2 watch_pwr_sel_ff == 2'h1)
        else $error("watch power select wrong");
    a_wake_on_act: assert property (
        op_mode == 3'h2 && activity |=> wake_req_ff)
        else $error("no wake on activity");
    a_wake_only_watch: assert property (
        !(op_mode == 3'h2 && activity) |=> !wake_req_ff)
        else $error("wake outside watch mode");
    a_z_neg_drive: assert property (
        wr && addr == 8'h22 |=> z_neg_ff == $past(wdata[3]))
        else $error("z negative drive wrong");
    a_hs_enable_load: assert property (
        wr && addr == 8'h1c |=> hs_enable_ff == $past(wdata[7]))
        else $error("high speed enable not stored");
endmodule

bind pmst_regs pmst_regs_checker pmst_regs_checker_inst (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_ff(rdata_ff), .op_mode(op_mode), .activity(activity),
    .act_pwr_sel_ff(act_pwr_sel_ff), .watch_pwr_sel_ff(watch_pwr_sel_ff),
    .wake_req_ff(wake_req_ff), .x_pos_ff(x_pos_ff), .y_neg_ff(y_neg_ff),
    .z_pos_ff(z_pos_ff), .z_neg_ff(z_neg_ff),
    .hs_enable_ff(hs_enable_ff));

// [tb_pmst_regs.sv]
// self-checking bench for the power and self-test register bank
`timescale 1ns/1ps
module tb_pmst_regs;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  op_mode = 3'h0;
    logic        activity = 1'b0;
    wire  [7:0]  rdata_ff;
    wire  [1:0]  act_sel;
    wire  [1:0]  watch_sel;
    wire         wake;
    wire         hs;
    wire  [5:0]  drv;
    wire  [1:0]  init;
    int          fails = 0;
    int          compares = 0;
    logic [34:0] rows [11];
    logic [11:0] pw [4] = '{12'hcb6, 12'h349, 12'h550, 12'h436};
    logic [7:0]  ra, rdat, rexp;
    logic [2:0]  rop;
    logic [7:0]  rdrv;
    ////////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;

    pmst_regs pmst_regs_inst (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_ff(rdata_ff), .op_mode(op_mode), .activity(activity),
        .act_pwr_sel_ff(act_sel), .watch_pwr_sel_ff(watch_sel),
        .wake_req_ff(wake), .hs_enable_ff(hs), .x_pos_ff(drv[5]),
        .x_neg_ff(drv[4]), .y_pos_ff(drv[3]), .y_neg_ff(drv[2]),
        .z_pos_ff(drv[1]), .z_neg_ff(drv[0]), .x_init_ff(init[1]),
        .y_init_ff(init[0]));

    task check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data only stands one cycle, so sample mid-cycle
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata_ff, e);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        give_verdict;
    end

    initial begin
        rows = '{{8'h1c, 8'hcb, 3'h5, 8'h43, 8'h00},
                 {8'h1c, 8'h34, 3'h5, 8'h34, 8'h00},
                 {8'h20, 8'h05, 3'h5, 8'h00, 8'ha0},
                 {8'h20, 8'h09, 3'h5, 8'h00, 8'h90},
                 {8'h21, 8'h8c, 3'h5, 8'h80, 8'hdc},
                 {8'h21, 8'h84, 3'h0, 8'h00, 8'hd8},
                 {8'h21, 8'h88, 3'h1, 8'h00, 8'hd4},
                 {8'h22, 8'h0c, 3'h2, 8'h0c, 8'hd7},
                 {8'h22, 8'h04, 3'h6, 8'h04, 8'hd6},
                 {8'h23, 8'hff, 3'h7, 8'h00, 8'hd6},
                 {8'h21, 8'h80, 3'h7, 8'h80, 8'hd2}};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(8'h1c, 8'h00);
        rd_chk(8'h22, 8'h00);
        foreach (rows[i]) begin
            {ra, rdat, rop, rexp, rdrv} = rows[i];
            wr_reg(ra, rdat);
            op_mode <= rop;
            rd_chk(ra, rexp);
            check({init, drv}, rdrv);
        end
        // reserved codes included: they must read as low power
        foreach (pw[j]) begin
            wr_reg(8'h1c, pw[j][11:4]);
            repeat (2) @(posedge clk);
            @(negedge clk);
            check({4'h0, act_sel, watch_sel}, {4'h0, pw[j][3:0]});
            check({7'h0, hs}, {7'h0, pw[j][11]});
        end
        @(posedge clk);
        op_mode <= 3'h2;
        activity <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check({7'h0, wake}, 8'h01);
        // activity outside watch mode must not raise a wake request
        @(posedge clk);
        op_mode <= 3'h5;
        @(posedge clk);
        @(negedge clk);
        check({7'h0, wake}, 8'h00);
        @(posedge clk);
        activity <= 1'b0;
        arst_n <= 1'b0;
        @(negedge clk);
        check({init, drv}, 8'h00);
        check({3'h0, act_sel, watch_sel, hs}, 8'h00);
        @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(8'h22, 8'h00);
        give_verdict;
    end
endmodule
